// *** verilog/i2css_pkg.sv ***
/*
  Constants for the two-wire slave: register offsets, field positions,
  reset values, command codes and the state encoding.
  Assumes an 8-bit register port with a 4-bit address.
*/
package i2css_pkg;
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] OFF_MASTER_CONTROL_A = 4'h3;
  localparam logic [AW-1:0] OFF_CTRLA  = 4'h9;
  localparam logic [AW-1:0] OFF_CTRLB  = 4'hA;
  localparam logic [AW-1:0] OFF_STATUS = 4'hB;
  localparam logic [AW-1:0] OFF_ADDR   = 4'hC;
  localparam logic [AW-1:0] OFF_DATA   = 4'hD;
  // Field positions
  localparam int unsigned MEN_BIT   = 0;
  localparam int unsigned SEN_BIT   = 0;
  localparam int unsigned MATCH_ALL_ADDRESSES_MODE_BIT  = 2;
  localparam int unsigned ACKA_BIT  = 2;
  localparam int unsigned DIF_BIT   = 7;
  localparam int unsigned ADDR_OR_STOP_IRQ_FLAG_BIT  = 6;
  localparam int unsigned HOLD_BIT  = 5;
  localparam int unsigned RECEIVED_ACK_BIT_BIT = 4;
  localparam int unsigned TRANSMIT_COLLISION_FLAG_BIT  = 3;
  localparam int unsigned BERR_BIT  = 2;
  localparam int unsigned DIR_BIT   = 1;
  localparam int unsigned AP_BIT    = 0;
  localparam int unsigned GC_BIT    = 0;
  // Reset values
  localparam logic [DW-1:0] RST_REG  = 8'h00;
  localparam logic          RST_LINE = 1'h1;
  // Command codes
  localparam logic [1:0] NO_OPERATION_CODE         = 2'h0;
  localparam logic [1:0] RESERVED_CODE             = 2'h1;
  localparam logic [1:0] COMPLETE_TRANSACTION_CODE = 2'h2;
  localparam logic [1:0] RESPONSE_CODE             = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Where the link goes after an acknowledge bit
  typedef enum logic [1:0] {
    NX_RX   = 2'h0,
    NX_WAIT = 2'h1,
    NX_DIF  = 2'h2
  } i2css_next_t;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_RX   = 7'h02,
    S_HOLD = 7'h04,
    S_ACK  = 7'h08,
    S_TX   = 7'h10,
    S_RACK = 7'h20,
    S_WAIT = 7'h40
  } i2css_state_t;
endpackage

// *** verilog/i2css_top.sv ***
/*
  Two-wire bus slave with command, status and own-address registers.
  Assumes an external master drives SCL at no more than a quarter of
  sys_clk; SCL and SDA are open drain, resolved outside this module.
*/
`timescale 1ns/1ps
module i2css_top
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [i2css_pkg::AW-1:0] reg_addr,
  input  wire logic [i2css_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [i2css_pkg::DW-1:0] reg_rdata,
  input  wire logic                   scl_in,
  output logic                        scl_out,
  output logic                        scl_oe,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe
);
  import i2css_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: level changes once stages two and three agree
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic       scl_f_q;
  logic       sda_f_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s_q <= {3{RST_LINE}};
      sda_s_q <= {3{RST_LINE}};
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_f_q <= RST_LINE;
      sda_f_q <= RST_LINE;
    end
    else
    begin
      if (scl_s_q[1] == scl_s_q[2])
        scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_f_q <= sda_s_q[2];
    end
  end

  // SDA moves only while SCL stays high for a Start or Stop
  assign scl_rise = (scl_s_q[1] == scl_s_q[2]) && scl_s_q[2] && !scl_f_q;
  assign scl_fall = (scl_s_q[1] == scl_s_q[2]) && !scl_s_q[2] && scl_f_q;
  assign start_ev = scl_f_q && (sda_s_q[1] == sda_s_q[2]) && !sda_s_q[2]
                    && sda_f_q;
  assign stop_ev  = scl_f_q && (sda_s_q[1] == sda_s_q[2]) && sda_s_q[2]
                    && !sda_f_q;

  ////////////////////////////////////////////////////////////////////
  // Register decode
  logic          master_en_q;
  logic          slave_en_q;
  logic          match_all_q;
  logic          ack_action_q;
  logic [DW-1:0] own_addr_q;
  logic          wr_ctrlb;
  logic          wr_status;
  logic          data_wr;
  logic          data_rd;
  logic          cmd_valid;
  logic          sw_access;
  logic [1:0]    cmd;

  assign wr_ctrlb  = reg_wr && (reg_addr == OFF_CTRLB);
  assign wr_status = reg_wr && (reg_addr == OFF_STATUS);
  assign data_wr   = reg_wr && (reg_addr == OFF_DATA);
  assign data_rd   = reg_rd && (reg_addr == OFF_DATA);
  assign cmd       = wr_ctrlb ? reg_wdata[1:0] : NO_OPERATION_CODE;
  // Only codes 2 and 3 execute; reserved and no-op only store the acknowledge bit
  assign cmd_valid = wr_ctrlb && cmd[1];
  assign sw_access = data_wr || data_rd || cmd_valid;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      master_en_q  <= 1'h0;
      slave_en_q   <= 1'h0;
      match_all_q  <= 1'h0;
      ack_action_q <= 1'h0;
      own_addr_q   <= RST_REG;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFF_MASTER_CONTROL_A: master_en_q <= reg_wdata[MEN_BIT];
        OFF_CTRLA:
        begin
          slave_en_q  <= reg_wdata[SEN_BIT];
          match_all_q <= reg_wdata[MATCH_ALL_ADDRESSES_MODE_BIT];
        end
        OFF_CTRLB: ack_action_q <= reg_wdata[ACKA_BIT];
        OFF_ADDR: own_addr_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link state machine
  i2css_state_t  state_q;
  i2css_next_t   nxt_q;
  logic [3:0]    cnt_q;
  logic [DW-1:0] shreg_q;
  logic          is_addr_q;
  logic          pend_addr_q;
  logic          addressed_q;
  logic          dir_q;
  logic          ap_q;
  logic          received_ack_bit_q;
  logic          dif_q;
  logic          addr_or_stop_irq_flag_q;
  logic          transmit_collision_flag_q;
  logic          illegal_bus_condition_flag_q;
  logic          addr_match;
  logic          byte_in;
  logic          dif_set;
  logic          addr_or_stop_irq_flag_set;
  logic          transmit_collision_flag_set;
  logic          berr_set;
  logic          pend_w1c;
  logic          mid_byte;

  // General call when bit 0 of the own address allows it, or when match-all is set
  assign addr_match = match_all_q
                      || (shreg_q[7:1] == own_addr_q[7:1])
                      || (own_addr_q[GC_BIT] && shreg_q[7:1] == 7'h00);
  assign byte_in  = (state_q == S_RX) && scl_fall && (cnt_q == BYTE_BITS);
  // First clock of a received data byte may legally carry a Stop or repeated Start
  assign mid_byte = ((state_q == S_RX) && (cnt_q > 4'h1) && !is_addr_q)
                    || ((state_q == S_RX) && is_addr_q)
                    || (state_q == S_TX) || (state_q == S_RACK)
                    || (state_q == S_ACK);
  // Start then Stop at once, or any condition inside a byte
  assign berr_set = master_en_q && slave_en_q
                    && (start_ev || stop_ev) && mid_byte;
  assign pend_w1c = wr_status && (pend_addr_q ? reg_wdata[ADDR_OR_STOP_IRQ_FLAG_BIT]
                                              : reg_wdata[DIF_BIT]);
  assign dif_set  = (byte_in && !is_addr_q)
                    || ((state_q == S_ACK) && scl_fall && nxt_q == NX_DIF)
                    || ((state_q == S_RACK) && scl_fall);
  assign addr_or_stop_irq_flag_set = (byte_in && is_addr_q && addr_match)
                    || (stop_ev && addressed_q && slave_en_q);
  // Released line read back low while a one was meant
  assign transmit_collision_flag_set = scl_rise && !sda_f_q
                    && (((state_q == S_TX) && shreg_q[7])
                        || ((state_q == S_ACK) && ack_action_q));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q     <= S_IDLE;
      nxt_q       <= NX_RX;
      cnt_q       <= 4'h0;
      is_addr_q   <= 1'h0;
      pend_addr_q <= 1'h0;
    end
    else if (!slave_en_q)
      state_q <= S_IDLE;
    else if (stop_ev || berr_set)
      state_q <= S_IDLE;
    else if (start_ev)
    begin
      state_q   <= S_RX;
      cnt_q     <= 4'h0;
      is_addr_q <= 1'h1;
    end
    else
    begin
      case (state_q)
        S_RX:
        begin
          if (scl_rise)
            cnt_q <= cnt_q + 4'h1;
          if (byte_in)
          begin
            pend_addr_q <= is_addr_q;
            state_q     <= (is_addr_q && !addr_match) ? S_WAIT : S_HOLD;
          end
        end
        S_HOLD:
        begin
          cnt_q <= 4'h0;
          if (cmd_valid && cmd == COMPLETE_TRANSACTION_CODE)
          begin
            nxt_q   <= NX_WAIT;
            state_q <= dir_q ? S_WAIT : S_ACK;
          end
          else if (cmd_valid && pend_addr_q)
          begin
            nxt_q   <= dir_q ? NX_DIF : NX_RX;
            state_q <= S_ACK;
          end
          else if (cmd_valid || data_wr)
          begin
            nxt_q   <= NX_RX;
            state_q <= (dir_q || data_wr) ? S_TX : S_ACK;
          end
          else if (data_rd && !dir_q)
          begin
            nxt_q   <= NX_RX;
            state_q <= S_ACK;
          end
          else if (pend_w1c)
            state_q <= S_WAIT;
        end
        S_ACK:
          if (scl_fall)
          begin
            is_addr_q   <= 1'h0;
            pend_addr_q <= 1'h0;
            case (nxt_q)
              NX_RX: state_q <= S_RX;
              NX_DIF: state_q <= S_HOLD;
              default: state_q <= S_WAIT;
            endcase
          end
        S_TX:
          if (scl_fall)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == BYTE_BITS - 4'h1)
              state_q <= S_RACK;
          end
        S_RACK:
          if (scl_fall)
          begin
            pend_addr_q <= 1'h0;
            state_q     <= S_HOLD;
          end
        S_IDLE, S_WAIT: ;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Shift register: loads from software only while the clock is held
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      shreg_q <= RST_REG;
    else if ((state_q == S_RX) && scl_rise)
      shreg_q <= {shreg_q[DW-2:0], sda_f_q};
    else if ((state_q == S_TX) && scl_fall)
      shreg_q <= {shreg_q[DW-2:0], 1'h0};
    else if ((state_q == S_HOLD) && data_wr)
      shreg_q <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set beats a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dif_q    <= 1'h0;
      addr_or_stop_irq_flag_q   <= 1'h0;
      transmit_collision_flag_q   <= 1'h0;
      illegal_bus_condition_flag_q <= 1'h0;
    end
    else
    begin
      dif_q <= dif_set
               || (dif_q && !sw_access
                   && !(wr_status && reg_wdata[DIF_BIT]));
      addr_or_stop_irq_flag_q <= addr_or_stop_irq_flag_set
                || (addr_or_stop_irq_flag_q && !sw_access
                    && !(wr_status && reg_wdata[ADDR_OR_STOP_IRQ_FLAG_BIT]));
      transmit_collision_flag_q <= transmit_collision_flag_set
                || (transmit_collision_flag_q && !start_ev
                    && !(wr_status && reg_wdata[TRANSMIT_COLLISION_FLAG_BIT]));
      illegal_bus_condition_flag_q <= berr_set
                  || (illegal_bus_condition_flag_q && !(wr_status && reg_wdata[BERR_BIT]));
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dir_q       <= 1'h0;
      ap_q        <= 1'h0;
      received_ack_bit_q     <= 1'h0;
      addressed_q <= 1'h0;
    end
    else
    begin
      if (byte_in && is_addr_q && addr_match)
      begin
        dir_q       <= shreg_q[0];
        ap_q        <= 1'h1;
        addressed_q <= 1'h1;
      end
      else if (stop_ev)
      begin
        if (addressed_q && slave_en_q)
          ap_q <= 1'h0;
        addressed_q <= 1'h0;
      end
      if ((state_q == S_RACK) && scl_rise)
        received_ack_bit_q <= sda_f_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pins: open drain, so only the enables ever change
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe  = (state_q == S_HOLD);
  // No low drive on SDA once a collision is seen
  assign sda_oe  = !transmit_collision_flag_q
                   && (((state_q == S_ACK) && !ack_action_q)
                       || ((state_q == S_TX) && !shreg_q[7]));

  ////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= RST_REG;
    else if (!reg_rd)
      reg_rdata <= RST_REG;
    else
    begin
      case (reg_addr)
        OFF_MASTER_CONTROL_A: reg_rdata <= {7'h00, master_en_q};
        OFF_CTRLA: reg_rdata <= {5'h00, match_all_q, 1'h0, slave_en_q};
        OFF_CTRLB: reg_rdata <= {5'h00, ack_action_q, 2'h0};
        OFF_STATUS: reg_rdata <= {dif_q, addr_or_stop_irq_flag_q, scl_oe, received_ack_bit_q,
                                  transmit_collision_flag_q, illegal_bus_condition_flag_q, dir_q, ap_q};
        OFF_ADDR: reg_rdata <= own_addr_q;
        OFF_DATA: reg_rdata <= shreg_q;
        default: reg_rdata <= RST_REG;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence addr_done_s;
    byte_in && is_addr_q && addr_match && !stop_ev && !start_ev
      && slave_en_q;
  endsequence
  sequence comp_cmd_s;
    (state_q == S_HOLD) && cmd_valid && cmd == COMPLETE_TRANSACTION_CODE
      && !start_ev && !stop_ev && slave_en_q;
  endsequence

  cmd_reads_zero_a: assert property (
    reg_rd && reg_addr == OFF_CTRLB |=> reg_rdata[1:0] == 2'h0)
    else $error("command field read back nonzero");
  ack_bit_store_a: assert property (
    wr_ctrlb ##1 (reg_rd && reg_addr == OFF_CTRLB && !reg_wr)
      |=> reg_rdata[ACKA_BIT] == $past(reg_wdata[ACKA_BIT], 2))
    else $error("acknowledge bit not stored");
  addr_flags_a: assert property (
    addr_done_s |=> addr_or_stop_irq_flag_q && ap_q && scl_oe
      && dir_q == $past(shreg_q[0]))
    else $error("address match flags wrong");
  comp_trans_a: assert property (
    comp_cmd_s |=> (dir_q ? state_q == S_WAIT : state_q == S_ACK)
      && !dif_q && !addr_or_stop_irq_flag_q)
    else $error("complete transaction misbehaved");
  dif_clear_a: assert property (
    data_rd && !dif_set |=> !dif_q)
    else $error("data flag survived data read");
  stretch_flag_a: assert property (
    $rose(dif_q) && slave_en_q && !stop_ev && !start_ev |-> ##1 scl_oe)
    else $error("clock not held with data flag");
  transmit_collision_flag_quiet_a: assert property (
    transmit_collision_flag_q |-> !sda_oe)
    else $error("low drive after collision");
  transmit_collision_flag_start_a: assert property (
    start_ev |=> !transmit_collision_flag_q)
    else $error("collision not cleared by start");
  rsv_cmd_a: assert property (
    wr_ctrlb && cmd == RESERVED_CODE && state_q == S_HOLD
      && !start_ev && !stop_ev && slave_en_q
      |=> state_q == S_HOLD && dif_q == $past(dif_q)
        && addr_or_stop_irq_flag_q == $past(addr_or_stop_irq_flag_q))
    else $error("reserved command had an effect");
  berr_gate_a: assert property (
    !master_en_q && !(wr_status && reg_wdata[BERR_BIT]) |=>
      illegal_bus_condition_flag_q == $past(illegal_bus_condition_flag_q))
    else $error("bus error set with master disabled");
  slave_off_a: assert property (
    !slave_en_q |=> state_q == S_IDLE && !sda_oe)
    else $error("disabled slave left idle");
endmodule

// *** tb/i2css_bus_master.sv ***
/*
  Behavioural two-wire bus master used as the slave's far side.
  Assumes the bench resolves both open-drain wires from every driver.
*/
`timescale 1ns/1ps
module i2css_bus_master
(
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_low,
  output logic      sda_low
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Released clock may be stretched; bounded so a stuck slave shows up
  task automatic rise();
    scl_low = 1'b0;
    repeat (400)
      if (scl_w !== 1'b1)
        #10;
  endtask

  task automatic start();
    sda_low = 1'b1;
    #80 scl_low = 1'b1;
    #80;
  endtask

  // SDA moves only a hold time after SCL falls, never with it
  task automatic stop();
    #40 sda_low = 1'b1;
    #40 rise();
    #80 sda_low = 1'b0;
    #80;
  endtask

  task automatic put_bit(input logic b);
    #40 sda_low = ~b;
    #40 rise();
    #80 scl_low = 1'b1;
  endtask

  // Force low on a bit the slave sends high provokes a collision
  task automatic get_bit(input logic f, output logic b);
    #40 sda_low = f;
    #40 rise();
    #40 b = sda_w;
    #40 scl_low = 1'b1;
  endtask

  task automatic send8(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    #40 sda_low = 1'b0;
    #40;
  endtask

  task automatic recv8(input logic [7:0] f, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(f[i], d[i]);
    #80;
  endtask
endmodule

// *** tb/tb_i2css_top.sv ***
/*
  Self-checking bench for the two-wire slave: register port driven here,
  bus side driven by the master model. Assumes the pins are open drain.
*/
`timescale 1ns/1ps
module tb_i2css_top;
  import i2css_pkg::*;
  logic          sys_clk, rst, reg_wr, reg_rd, rd_p, b;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rnd, rbyte;
  logic          scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
  logic [15:0]   ent;
  logic [15:0]   exp_q[$];
  int            error_cnt = 0;
  int            comparisons = 0;
  wire logic     scl_w = ~((scl_oe & ~scl_out) | m_scl);
  wire logic     sda_w = ~((sda_oe & ~sda_out) | m_sda);

  i2css_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  i2css_bus_master m (.scl_w(scl_w), .sda_w(sda_w), .scl_low(m_scl),
    .sda_low(m_sda));

  initial
  begin
    sys_clk = 1'b0;
    forever
      #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic s);
    chk_byte(n, {7'h00, e}, {7'h00, s});
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Expected value noted with its mask; monitor compares under the mask
  task automatic rd(input logic [AW-1:0] a, input logic [7:0] e,
                    input logic [7:0] mk);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back({mk, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Write then read with no gap between the two strobes
  task automatic wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d,
                       input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back({8'hFF, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk)
    rd_p <= reg_rd;
  always @(negedge sys_clk)
    if (rd_p === 1'b1 && exp_q.size() > 0)
    begin
      ent = exp_q.pop_front();
      chk_byte("reg_rdata", ent[7:0] & ent[15:8], reg_rdata & ent[15:8]);
    end

  initial
  begin
    #400us;
    $display("watchdog expired");
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1; reg_addr = '0; reg_wdata = '0;
    reg_wr = 1'b0; reg_rd = 1'b0; rd_p = 1'b0;
    void'($urandom(75));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    rd(OFF_CTRLB, RST_REG, 8'hFF);
    rd(OFF_STATUS, RST_REG, 8'hFF);
    rd(OFF_ADDR, RST_REG, 8'hFF);
    wr(OFF_CTRLB, 8'h05);
    rd(OFF_CTRLB, 8'h04, 8'hFF);
    rnd = 8'($urandom);
    wr_rd(OFF_CTRLB, rnd, {5'h00, rnd[2], 2'h0});
    rnd = $urandom;
    wr(OFF_ADDR, rnd);
    rd(OFF_ADDR, rnd, 8'hFF);
    wr({2'h1, rnd[1:0]}, 8'hFF);
    rd({2'h1, rnd[1:0]}, 8'h00, 8'hFF);
    $display("test registers done");
    wr(OFF_MASTER_CONTROL_A, 8'h01); wr(OFF_CTRLA, 8'h01);
    wr(OFF_ADDR, 8'hB4); wr(OFF_CTRLB, 8'h01);
    rd(OFF_STATUS, 8'h00, 8'hFF);
    m.start(); m.send8(8'hB4);
    rd(OFF_STATUS, 8'h61, 8'hFF);
    chk_bit("scl_oe", 1'b1, scl_oe);
    chk_byte("pin levels", 8'h00, {6'h00, scl_out, sda_out});
    wr(OFF_CTRLB, 8'h01);
    rd(OFF_STATUS, 8'h61, 8'hFF);
    wr(OFF_CTRLB, 8'h03);
    m.get_bit(1'b0, b); chk_bit("addr ack", 1'b0, b);
    rnd = $urandom;
    m.send8(rnd);
    rd(OFF_STATUS, 8'hA0, 8'hE0);
    rd(OFF_DATA, rnd, 8'hFF);
    rd(OFF_STATUS, 8'h00, 8'hE0);
    m.get_bit(1'b0, b); chk_bit("data ack", 1'b0, b);
    m.send8(8'h3C);
    wr(OFF_CTRLB, 8'h03);
    m.get_bit(1'b0, b); chk_bit("cmd3 ack", 1'b0, b);
    wr(OFF_CTRLB, 8'h04);
    m.send8(8'h11);
    rd(OFF_DATA, 8'h11, 8'hFF);
    m.get_bit(1'b0, b); chk_bit("data nack", 1'b1, b);
    m.stop(); settle();
    rd(OFF_STATUS, 8'h40, 8'hE5);
    wr(OFF_STATUS, 8'h40);
    rd(OFF_STATUS, 8'h00, 8'h40);
    $display("test master write done");
    wr(OFF_CTRLB, 8'h00);
    m.start(); m.send8(8'hB5);
    rd(OFF_STATUS, 8'h63, 8'hE3);
    wr(OFF_CTRLB, 8'h03);
    m.get_bit(1'b0, b); chk_bit("read ack", 1'b0, b);
    settle();
    rd(OFF_STATUS, 8'hA0, 8'hE0);
    wr(OFF_DATA, 8'hC3);
    m.recv8(8'h80, rbyte);
    chk_byte("collided byte", 8'h7F, rbyte);
    m.put_bit(1'b1); settle();
    rd(OFF_STATUS, 8'h98, 8'hD8);
    chk_bit("scl_oe", 1'b1, scl_oe);
    wr(OFF_STATUS, 8'h88);
    rd(OFF_STATUS, 8'h00, 8'hA8);
    chk_bit("scl_oe", 1'b0, scl_oe);
    m.stop(); settle();
    wr(OFF_STATUS, 8'h40);
    $display("test master read done");
    m.start(); m.stop(); settle();
    rd(OFF_STATUS, 8'h04, 8'h04);
    wr(OFF_STATUS, 8'h04);
    rd(OFF_STATUS, 8'h00, 8'h04);
    wr(OFF_MASTER_CONTROL_A, 8'h00);
    m.start(); m.stop(); settle();
    rd(OFF_STATUS, 8'h00, 8'h04);
    $display("test bus error done");
    m.start(); m.send8(8'h20);
    rd(OFF_STATUS, 8'h00, 8'h40);
    chk_bit("scl_oe", 1'b0, scl_oe);
    m.stop();
    wr(OFF_CTRLA, 8'h05);
    m.start(); m.send8(8'h20);
    rd(OFF_STATUS, 8'h61, 8'hE3);
    wr(OFF_CTRLB, 8'h02);
    m.get_bit(1'b0, b); chk_bit("cmd2 ack", 1'b0, b);
    m.send8(8'h55);
    rd(OFF_STATUS, 8'h00, 8'hA0);
    m.get_bit(1'b0, b); chk_bit("idle ack", 1'b1, b);
    m.stop(); settle();
    $display("test addressing done");
    give_verdict();
  end
endmodule
